// File: hw/trps_defines.svh
`ifndef TRPS_DEFINES_SVH
`define TRPS_DEFINES_SVH

// timebase: 1 MHz tick derived from the 125 MHz clock
`define TRPS_CLK_MHZ        125
`define TRPS_TICK_MHZ       1
`define TRPS_TICK_DIV       (`TRPS_CLK_MHZ / `TRPS_TICK_MHZ)
// times in microseconds, counted in 1 MHz ticks
`define TRPS_PHASE_US       1000
`define TRPS_SOFTSTART_US   3000
`define TRPS_PUMP_RAMP_US   4000
`define TRPS_NEG_DELAY_US   16000
`define TRPS_POS_DELAY_US   4000
// current limit steps, quarter of full per step
`define TRPS_ILIM_PHASE1    3'h1
`define TRPS_ILIM_FULL      3'h4
// ramp code full-scale value for the pump rise-rate control
`define TRPS_RAMP_MAX       8'hFF

`endif

// File: hw/trps_pkg.sv
package trps_pkg;

  typedef enum logic [6:0] {
    TRPS_OFF     = 7'h01,
    TRPS_REF     = 7'h02,
    TRPS_BOOST   = 7'h04,
    TRPS_NEG     = 7'h08,
    TRPS_POS     = 7'h10,
    TRPS_READY   = 7'h20,
    TRPS_SPARE   = 7'h40
  } trps_state_e;

  // comparator results, one bit per threshold
  typedef struct packed {
    logic ref_ok;        // reference in regulation
    logic ref_fault;     // reference below 1.05 V
    logic boost_reg;     // boost feedback in regulation
    logic boost_fault;   // boost feedback below 1.1 V
    logic neg_up;        // neg feedback below 110 mV
    logic neg_fault;     // neg feedback above 130 mV
    logic pos_up;        // pos feedback above 1.125 V
    logic pos_fault;     // pos feedback below 1.11 V
  } trps_cmp_s;

  typedef struct packed {
    logic       ref_en;
    logic       ref_ground;
    logic       boost_en;
    logic [2:0] boost_ilim;
    logic       neg_en;
    logic [7:0] neg_ramp;
    logic       pos_en;
    logic [7:0] pos_ramp;
  } trps_ctl_s;

endpackage : trps_pkg

// File: hw/trps_sequencer.sv
`timescale 1ns/1ps
`include "trps_defines.svh"
// Overview of operation
// RQ1 - boost start enters soft-start phase one at quarter current limit
// RQ2 - each 1 ms without regulation advances phase, adding a quarter step
// RQ3 - full current limit after 3 ms or at boost regulation, whichever first
// RQ4 - each charge pump ramps its rise rate to regulate within 4 ms
// RQ5 - power-down request low disables all converters, reference grounded
// RQ6 - power-up or power-down release restarts the sequence from the start
// RQ7 - host must drive power-down request to a defined level, tie high unused
// RQ8 - no-delay variant: reference first, then soft-started boost
// RQ9 - no-delay variant: negative pump on once boost is regulated
// RQ10 - no-delay variant: positive pump on when neg feedback below 110 mV
// RQ11 - ready asserts low when positive feedback exceeds 1.125 V
// RQ12 - delayed variant: boost enabled only after reference regulates
// RQ13 - delayed variant: neg pump needs boost regulated and 16 ms elapsed
// RQ14 - delayed variant: pos pump needs neg up and 4 ms since neg enable
// RQ15 - ready is open-drain: driven low when done, released on fault
// RQ16 - after ready, any output below fault threshold releases ready
// RQ17 - reference fault below 1.05 V, boost fault below 1.1 V
// RQ18 - neg fault above 130 mV, pos fault below 1.11 V
// RQ19 - a fault stops later rails, keeps earlier, restarts after recovery
// RQ20 - timers count a fixed 1 MHz timebase
// RQ21 - shutdown clears all state, timers and fault latches; the code keeps the ramp_div_reg count through shutdown
// RQ22 - sequencing variant is a build-time parameter
module trps_sequencer #(
  parameter bit               DELAYED       = 1'b0,  // RQ22
  parameter int unsigned      NEG_DELAY_TICKS = `TRPS_NEG_DELAY_US,
  parameter int unsigned      POS_DELAY_TICKS = `TRPS_POS_DELAY_US
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire logic               power_down_request_n,
  input  wire trps_pkg::trps_cmp_s cmp_in,
  output trps_pkg::trps_ctl_s     ctl,
  output logic                    ready_n_o,
  output logic                    ready_n_oe,
  output logic                    ready_n_i_unused,
  output trps_pkg::trps_state_e   state
);
  import trps_pkg::*;

  // pins from the analog side cross into this domain through two flops
  logic       pdr_s1_reg;
  logic       pdr_s2_reg;
  trps_cmp_s  cmp_s1_reg;
  trps_cmp_s  cmp_s2_reg;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      pdr_s1_reg <= 1'b0;
      pdr_s2_reg <= 1'b0;
      cmp_s1_reg <= '0;
      cmp_s2_reg <= '0;
    end
    else if (clk_en)
    begin
      pdr_s1_reg <= power_down_request_n;
      pdr_s2_reg <= pdr_s1_reg;
      cmp_s1_reg <= cmp_in;
      cmp_s2_reg <= cmp_s1_reg;
    end

  wire       run = pdr_s2_reg;
  trps_cmp_s c;
  assign c = cmp_s2_reg;

  // 1 MHz tick from the 125 MHz clock
  localparam int unsigned TICK_DIV = `TRPS_TICK_DIV;  // RQ20
  logic [6:0] div_reg;
  wire        tick = (div_reg == 7'(TICK_DIV - 1));

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      div_reg <= 7'h00;
    else if (clk_en)
      div_reg <= (!run || tick) ? 7'h00 : div_reg + 7'h01;  // RQ20

  // state machine
  trps_state_e state_reg;
  trps_state_e state_next;
  assign state = state_reg;

  wire boost_go = DELAYED ? c.ref_ok : 1'b1;  // RQ8 RQ12
  logic [14:0] neg_tmr_reg;
  logic [12:0] pos_tmr_reg;
  wire neg_wait_done = !DELAYED || (neg_tmr_reg >= 15'(NEG_DELAY_TICKS));  // RQ13
  wire pos_wait_done = !DELAYED || (pos_tmr_reg >= 13'(POS_DELAY_TICKS));  // RQ14
  wire neg_go = c.boost_reg && neg_wait_done;  // RQ9 RQ13
  wire pos_go = c.neg_up && pos_wait_done;  // RQ10 RQ14

  // falling back to the faulted rail's own state keeps earlier rails and drops later ones
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TRPS_OFF:   state_next = TRPS_REF;  // RQ6
      TRPS_REF:   if (boost_go) state_next = TRPS_BOOST;  // RQ8 RQ12
      TRPS_BOOST:
        if (c.ref_fault) state_next = TRPS_REF;  // RQ19
        else if (neg_go) state_next = TRPS_NEG;
      TRPS_NEG:
        if (c.ref_fault) state_next = TRPS_REF;  // RQ19
        else if (c.boost_fault) state_next = TRPS_BOOST;  // RQ19
        else if (pos_go) state_next = TRPS_POS;
      TRPS_POS:
        if (c.ref_fault) state_next = TRPS_REF;  // RQ19
        else if (c.boost_fault) state_next = TRPS_BOOST;  // RQ19
        else if (c.neg_fault) state_next = TRPS_NEG;  // RQ19
        else if (c.pos_up) state_next = TRPS_READY;  // RQ11
      TRPS_READY:
        if (c.ref_fault) state_next = TRPS_REF;  // RQ16 RQ17
        else if (c.boost_fault) state_next = TRPS_BOOST;  // RQ16 RQ17
        else if (c.neg_fault) state_next = TRPS_NEG;  // RQ16 RQ18
        else if (c.pos_fault) state_next = TRPS_POS;  // RQ16 RQ18
      default:    state_next = TRPS_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      state_reg <= TRPS_OFF;
    else if (clk_en)
      state_reg <= run ? state_next : TRPS_OFF;  // RQ5 RQ21

  wire in_boost = (state_reg == TRPS_BOOST);
  wire in_neg   = (state_reg == TRPS_NEG);
  wire in_pos   = (state_reg == TRPS_POS);
  wire boost_on = in_boost || in_neg || in_pos || (state_reg == TRPS_READY);
  wire neg_on   = in_neg || in_pos || (state_reg == TRPS_READY);
  wire pos_on   = in_pos || (state_reg == TRPS_READY);

  // soft-start: ticks since boost enable, phase from elapsed milliseconds
  logic [11:0] ss_tmr_reg;
  logic        ss_done_reg;
  wire [2:0]   ss_phase = 3'(ss_tmr_reg / 12'(`TRPS_PHASE_US)) + `TRPS_ILIM_PHASE1;  // RQ1 RQ2
  wire         ss_end = (ss_tmr_reg >= 12'(`TRPS_SOFTSTART_US)) || c.boost_reg;  // RQ3
  // limit taken straight into the output flop, so it moves with boost enable, except at power-down, where it clears one cycle after boost enable drops
  wire [2:0]   ilim_next = !boost_on ? 3'h0 :
                           (ss_done_reg || ss_end) ? `TRPS_ILIM_FULL : ss_phase;  // RQ1 RQ3

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      ss_tmr_reg  <= 12'h000;
      ss_done_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!boost_on)
      begin
        ss_tmr_reg  <= 12'h000;  // RQ21
        ss_done_reg <= 1'b0;
      end
      else
      begin
        if (tick && !ss_done_reg)
          ss_tmr_reg <= ss_tmr_reg + 12'h001;  // RQ2
        if (ss_end)
          ss_done_reg <= 1'b1;  // RQ3
      end
    end

  // delay timers, saturating, cleared while their rail start is off
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      neg_tmr_reg <= 15'h0000;
      pos_tmr_reg <= 13'h0000;
    end
    else if (clk_en)
    begin
      if (!boost_on)
        neg_tmr_reg <= 15'h0000;  // RQ21
      else if (tick && !neg_wait_done)
        neg_tmr_reg <= neg_tmr_reg + 15'h0001;  // RQ13
      if (!neg_on)
        pos_tmr_reg <= 13'h0000;  // RQ21
      else if (tick && !pos_wait_done)
        pos_tmr_reg <= pos_tmr_reg + 13'h0001;  // RQ14
    end

  // pump rise-rate ramps: full scale in 255 steps of 15 ticks, just under 4 ms, so regulation is reached in time
  localparam int unsigned RAMP_STEP_TICKS = `TRPS_PUMP_RAMP_US / 256;
  logic [3:0] ramp_div_reg;
  logic [7:0] neg_ramp_reg;
  logic [7:0] pos_ramp_reg;
  wire        ramp_tick = tick && (ramp_div_reg == 4'(RAMP_STEP_TICKS - 1));

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      ramp_div_reg <= 4'h0;
      neg_ramp_reg <= 8'h00;
      pos_ramp_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      if (tick)
        ramp_div_reg <= ramp_tick ? 4'h0 : ramp_div_reg + 4'h1;
      if (!neg_on)
        neg_ramp_reg <= 8'h00;  // RQ4
      else if (ramp_tick && neg_ramp_reg != `TRPS_RAMP_MAX)
        neg_ramp_reg <= neg_ramp_reg + 8'h01;  // RQ4
      if (!pos_on)
        pos_ramp_reg <= 8'h00;  // RQ4
      else if (ramp_tick && pos_ramp_reg != `TRPS_RAMP_MAX)
        pos_ramp_reg <= pos_ramp_reg + 8'h01;  // RQ4
    end

  // outputs from flops; ready low only in the ready state
  logic ready_drv_reg;
  trps_ctl_s ctl_reg;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      ready_drv_reg <= 1'b0;
      ctl_reg       <= '{ref_ground: 1'b1, default: '0};
    end
    else if (clk_en)
    begin
      ready_drv_reg      <= run && (state_next == TRPS_READY);  // RQ11 RQ15 RQ16
      ctl_reg.ref_en     <= run;  // RQ5
      ctl_reg.ref_ground <= !run;  // RQ5
      ctl_reg.boost_en   <= run && boost_on;
      ctl_reg.boost_ilim <= ilim_next;  // RQ1 RQ2 RQ3
      ctl_reg.neg_en     <= run && neg_on;
      ctl_reg.neg_ramp   <= neg_ramp_reg;
      ctl_reg.pos_en     <= run && pos_on;
      ctl_reg.pos_ramp   <= pos_ramp_reg;
    end

  assign ctl              = ctl_reg;
  assign ready_n_o        = 1'b0;  // RQ15
  assign ready_n_oe       = ready_drv_reg;  // RQ15
  assign ready_n_i_unused = 1'b0;

endmodule : trps_sequencer

// File: testbench/trps_host_model.sv
`timescale 1ns/1ps
module trps_host_model (
  input  wire logic run,
  input  wire logic ready_n_o,
  input  wire logic ready_n_oe,
  output logic      power_down_request_n,
  output logic      ready_pin
);
  // never floats: an unknown run request reads as shutdown
  assign power_down_request_n = (run === 1'b1);
  // pull-up on the open-drain line
  assign ready_pin = ready_n_oe ? ready_n_o : 1'b1;
endmodule : trps_host_model

// File: testbench/trps_seq_chk.sv
`timescale 1ns/1ps
`include "trps_defines.svh"
module trps_seq_chk #(
  parameter bit          DELAYED         = 1'b0,
  parameter int unsigned NEG_DELAY_TICKS = 16000,
  parameter int unsigned POS_DELAY_TICKS = 4000
) (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  clk_en,
  input wire logic                  power_down_request_n,
  input wire trps_pkg::trps_cmp_s   cmp_in,
  input wire trps_pkg::trps_ctl_s   ctl,
  input wire logic                  ready_n_o,
  input wire logic                  ready_n_oe,
  input wire logic                  ready_n_i_unused,
  input wire trps_pkg::trps_state_e state
);
  import trps_pkg::*;
  int unsigned boost_cnt;
  int unsigned neg_cnt;
  // one tick of slack: the 1 MHz phase is unknown at enable
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      boost_cnt <= 0;
      neg_cnt   <= 0;
    end
    else
    begin
      boost_cnt <= ctl.boost_en ? boost_cnt + 1 : 0;
      neg_cnt   <= ctl.neg_en ? neg_cnt + 1 : 0;
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  shut_all_off_a: assert property (
    (!power_down_request_n && clk_en) [*6] |-> ctl.ref_ground && !ctl.ref_en
    && !ctl.boost_en && !ctl.neg_en && !ctl.pos_en) else $error("rail on in shutdown");
  ready_when_done_a: assert property (
    ready_n_oe |-> state == TRPS_READY || $past(state) == TRPS_READY)
    else $error("ready driven early");
  od_low_only_a: assert property (ready_n_o == 1'b0) else $error("ready data high");
  boost_after_ref_a: assert property (ctl.boost_en |-> ctl.ref_en)
    else $error("boost without reference");
  neg_after_boost_a: assert property (ctl.neg_en |-> ctl.boost_en)
    else $error("neg pump without boost");
  pos_after_neg_a: assert property (ctl.pos_en |-> ctl.neg_en)
    else $error("pos pump without neg pump");
  ilim_first_a: assert property (
    $rose(ctl.boost_en) && !cmp_in.boost_reg |-> ctl.boost_ilim == 3'h1)
    else $error("soft-start not at first step");
  ilim_step_a: assert property (
    ctl.boost_en && $past(ctl.boost_en) && ctl.boost_ilim != $past(ctl.boost_ilim)
    |-> ctl.boost_ilim == $past(ctl.boost_ilim) + 3'h1 || ctl.boost_ilim == 3'h4)
    else $error("current limit jump");
  neg_wait_a: assert property (
    $rose(ctl.neg_en) |-> !DELAYED || boost_cnt >= (NEG_DELAY_TICKS - 1) * `TRPS_TICK_DIV)
    else $error("neg pump early");
  pos_wait_a: assert property (
    $rose(ctl.pos_en) |-> !DELAYED || neg_cnt >= (POS_DELAY_TICKS - 1) * `TRPS_TICK_DIV)
    else $error("pos pump early");
  fault_release_a: assert property (
    ready_n_oe && clk_en && cmp_in.pos_fault |-> ##[1:6] !ready_n_oe)
    else $error("ready kept on fault");
  cover property ($rose(ready_n_oe));
  cover property ($fell(ready_n_oe) && power_down_request_n);
  cover property ($rose(ctl.pos_en));
endmodule : trps_seq_chk
bind trps_sequencer trps_seq_chk #(.DELAYED(DELAYED), .NEG_DELAY_TICKS(NEG_DELAY_TICKS),
  .POS_DELAY_TICKS(POS_DELAY_TICKS)) u_chk (.clk(clk), .resetn(resetn), .clk_en(clk_en),
  .power_down_request_n(power_down_request_n), .cmp_in(cmp_in), .ctl(ctl),
  .ready_n_o(ready_n_o), .ready_n_oe(ready_n_oe), .ready_n_i_unused(ready_n_i_unused),
  .state(state));

// File: testbench/tb_triple_rail_power_sequencer.sv
`timescale 1ns/1ps
`include "trps_defines.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module tb_triple_rail_power_sequencer;
  import trps_pkg::*;
  localparam int unsigned NEG_T = 20;
  localparam int unsigned POS_T = 10;
  localparam int unsigned DIV   = `TRPS_TICK_DIV;
  logic        clk;
  logic        resetn;
  logic        clk_en;
  logic        run;
  logic        pdn_n;
  logic        ready_pin;
  logic        rdy_o;
  logic        rdy_oe;
  trps_cmp_s   cmp;
  trps_ctl_s   ctl;
  trps_ctl_s   ctl_nd;
  logic        nd_oe;
  trps_state_e state;
  int          n_fail;
  int          checked;
  int          cyc;
  trps_sequencer #(.DELAYED(1'b1), .NEG_DELAY_TICKS(NEG_T), .POS_DELAY_TICKS(POS_T)) dut (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .power_down_request_n(pdn_n),
    .cmp_in(cmp), .ctl(ctl), .ready_n_o(rdy_o), .ready_n_oe(rdy_oe),
    .ready_n_i_unused(), .state(state));
  // no-delay variant runs beside the delayed one on the same stimulus
  trps_sequencer #(.DELAYED(1'b0), .NEG_DELAY_TICKS(NEG_T), .POS_DELAY_TICKS(POS_T)) dut_nd (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .power_down_request_n(pdn_n),
    .cmp_in(cmp), .ctl(ctl_nd), .ready_n_o(), .ready_n_oe(nd_oe),
    .ready_n_i_unused(), .state());
  trps_host_model host (.run(run), .ready_n_o(rdy_o), .ready_n_oe(rdy_oe),
    .power_down_request_n(pdn_n), .ready_pin(ready_pin));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // delays are measured from the enable edge, or from task entry when boost is already on, with one tick of slack and 20 more cycles on the neg delay
  task automatic climb();
    int n;
    for (n = 0; n < 3000 && ctl.boost_en !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 4000 && ctl.neg_en !== 1'b1; n++) @(posedge clk);
    `CHK("neg delay", 1'b1, n >= (NEG_T - 1) * DIV - 20)
    for (n = 0; n < 2000 && ctl.pos_en !== 1'b1; n++) @(posedge clk);
    `CHK("pos delay", 1'b1, n >= (POS_T - 1) * DIV)
    for (n = 0; n < 50 && ready_pin !== 1'b0; n++) @(posedge clk);
    `CHK("ready", 1'b0, ready_pin)
    `CHK("ilim full", 3'h4, ctl.boost_ilim)
  endtask : climb
  task automatic fault_wait(input logic exp_ready);
    int n;
    for (n = 0; n < 3000 && ready_pin !== exp_ready; n++) @(posedge clk);
    `CHK("ready pin", exp_ready, ready_pin)
  endtask : fault_wait
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  initial
  begin
    resetn = 1'b0;
    clk_en = 1'b1;
    run = 1'b0;
    cmp = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("ref grounded", 1'b1, ctl.ref_ground)
    `CHK("ready idle", 1'b1, ready_pin)
    run <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK("ref on", 1'b1, ctl.ref_en)
    `CHK("boost waits", 1'b0, ctl.boost_en)
    `CHK("nd boost on", 1'b1, ctl_nd.boost_en)
    `CHK("nd neg waits", 1'b0, ctl_nd.neg_en)
    cmp.ref_ok <= 1'b1;
    for (int n = 0; n < 20 && ctl.boost_en !== 1'b1; n++) @(posedge clk);
    `CHK("first step", 3'h1, ctl.boost_ilim)
    cmp.boost_reg <= 1'b1;
    cmp.neg_up <= 1'b1;
    cmp.pos_up <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("nd neg on", 1'b1, ctl_nd.neg_en)
    `CHK("nd pos on", 1'b1, ctl_nd.pos_en)
    `CHK("nd ready", 1'b1, nd_oe)
    climb();
    cmp.neg_fault <= 1'b1;
    cmp.neg_up <= 1'b0;
    fault_wait(1'b1);
    repeat (10) @(posedge clk);
    `CHK("pos off", 1'b0, ctl.pos_en)
    `CHK("boost kept", 1'b1, ctl.boost_en)
    cmp.neg_fault <= 1'b0;
    cmp.neg_up <= 1'b1;
    fault_wait(1'b0);
    cmp.pos_fault <= 1'b1;
    cmp.pos_up <= 1'b0;
    fault_wait(1'b1);
    `CHK("neg kept", 1'b1, ctl.neg_en)
    cmp.pos_fault <= 1'b0;
    cmp.boost_fault <= 1'b1;
    cmp.boost_reg <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("neg off", 1'b0, ctl.neg_en)
    `CHK("ref kept", 1'b1, ctl.ref_en)
    run <= 1'b0;
    cmp <= 8'hAA;
    repeat (8) @(posedge clk);
    `CHK("boost off", 1'b0, ctl.boost_en)
    `CHK("ref grounded", 1'b1, ctl.ref_ground)
    `CHK("state off", TRPS_OFF, state)
    run <= 1'b1;
    climb();
    repeat (2000) @(posedge clk);
    `CHK("neg ramp", 1'b1, ctl.neg_ramp != 8'h00)
    end_of_test();
  end
endmodule : tb_triple_rail_power_sequencer
